// *** hdl/dual_slope_pkg.sv ***
package dual_slope_pkg;

    // ************************************************************
    // synchroniser sizing
    // ************************************************************
    // flip-flops between a pin and the first logic that reads it
    localparam int SYNC_STAGES = 2;
    // pins that pass the synchroniser: two controls and the comparator
    localparam int PIN_COUNT = 3;
    // bit positions of the pins inside the synchronised vector
    localparam int PIN_FIRST = 0;
    localparam int PIN_SECOND = 1;
    localparam int PIN_COMP = 2;

    // ************************************************************
    // types
    // ************************************************************
    // analog switch set driven toward the switch drivers
    typedef struct packed {
        logic zero_loop_switch;
        logic zero_feedback_switch;
        logic input_path_switch;
        logic reference_path_switch;
    } switch_set_type;

    // conversion phase decoded from the two control pins
    typedef enum logic [1:0] {
        ZERO_PHASE,
        INPUT_PHASE,
        REFERENCE_PHASE,
        UNUSED_COMBO
    } phase_type;

    // whole state of the sequencer
    typedef struct packed {
        phase_type phase;
        switch_set_type sw;
        logic comp;
        logic seq_err;
    } seq_state_type;

    // ************************************************************
    // reset values
    // ************************************************************
    // all switches open: the integrator is left alone at reset
    localparam switch_set_type SW_ALL_OPEN = '{1'b0, 1'b0, 1'b0, 1'b0};
    localparam seq_state_type STATE_RESET = '{
        phase: ZERO_PHASE,
        sw: SW_ALL_OPEN,
        comp: 1'b0,
        seq_err: 1'b0
    };

endpackage : dual_slope_pkg

// *** hdl/pin_synchroniser.sv ***
`timescale 1ns/1ps

// ****************************************************************
// multi-bit level synchroniser, one chain per bit
// ****************************************************************
module pin_synchroniser #(
    parameter int WIDTH = 3,
    parameter int STAGES = 2
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // fewer than two stages would let metastability reach logic
    initial begin
        if (STAGES < 2 || WIDTH < 1) begin
            $error("pin_synchroniser: STAGES must be >= 2, WIDTH >= 1");
        end
    end

    // chain of flops; only the last stage is read outside
    logic [STAGES-1:0][WIDTH-1:0] chain_r;

    // shift each pin through the chain
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chain_r <= '0;
        end else begin
            chain_r <= {chain_r[STAGES-2:0], async_in};
        end
    end

    // last stage drives the output
    assign sync_out = chain_r[STAGES-1];

endmodule : pin_synchroniser

// *** hdl/dual_slope_phase_sequencer.sv ***
// Function
// - three phases: zero, input, reference, in order
// - both low closes loop and feedback switches
// - both high closes only input switch
// - first low, second high: loop plus reference
// - comparator output high at integrator threshold
`timescale 1ns/1ps

module dual_slope_phase_sequencer (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic first_ctrl_pin,
    input wire logic second_ctrl_pin,
    input wire logic comp_raw,
    output dual_slope_pkg::switch_set_type switches,
    output dual_slope_pkg::phase_type phase,
    output logic comp_out,
    output logic seq_err
);

    // ************************************************************
    // pin synchronisation
    // ************************************************************
    // all three pins are asynchronous to ref_clk
    logic [dual_slope_pkg::PIN_COUNT-1:0] pins_async;
    // synchronised copies, safe for logic
    logic [dual_slope_pkg::PIN_COUNT-1:0] pins_sync;
    // synchronised first control pin
    logic first_s;
    // synchronised second control pin
    logic second_s;
    // synchronised comparator decision
    logic comp_s;

    assign pins_async[dual_slope_pkg::PIN_FIRST] = first_ctrl_pin;
    assign pins_async[dual_slope_pkg::PIN_SECOND] = second_ctrl_pin;
    assign pins_async[dual_slope_pkg::PIN_COMP] = comp_raw;

    pin_synchroniser #(
        .WIDTH(dual_slope_pkg::PIN_COUNT),
        .STAGES(dual_slope_pkg::SYNC_STAGES)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(pins_async),
        .sync_out(pins_sync)
    );

    assign first_s = pins_sync[dual_slope_pkg::PIN_FIRST];
    assign second_s = pins_sync[dual_slope_pkg::PIN_SECOND];
    assign comp_s = pins_sync[dual_slope_pkg::PIN_COMP];

    // ************************************************************
    // decode functions
    // ************************************************************
    // map the two control levels onto a phase
    function automatic dual_slope_pkg::phase_type decode_phase(
        input logic first_lvl,
        input logic second_lvl
    );
        dual_slope_pkg::phase_type ph;
        ph = dual_slope_pkg::UNUSED_COMBO;
        if (!first_lvl && !second_lvl) begin
            ph = dual_slope_pkg::ZERO_PHASE;
        end else if (first_lvl && second_lvl) begin
            ph = dual_slope_pkg::INPUT_PHASE;
        end else if (!first_lvl && second_lvl) begin
            ph = dual_slope_pkg::REFERENCE_PHASE;
        end
        return ph;
    endfunction : decode_phase

    // switch set for a phase
    function automatic dual_slope_pkg::switch_set_type switches_for(
        input dual_slope_pkg::phase_type ph
    );
        dual_slope_pkg::switch_set_type s;
        s = dual_slope_pkg::SW_ALL_OPEN;
        unique case (ph)
            dual_slope_pkg::ZERO_PHASE: begin
                s.zero_loop_switch = 1'b1;
                s.zero_feedback_switch = 1'b1;
            end
            dual_slope_pkg::INPUT_PHASE: begin
                s.input_path_switch = 1'b1;
            end
            dual_slope_pkg::REFERENCE_PHASE: begin
                s.zero_loop_switch = 1'b1;
                s.reference_path_switch = 1'b1;
            end
            // unused pin combination leaves everything open
            dual_slope_pkg::UNUSED_COMBO: begin
                s = dual_slope_pkg::SW_ALL_OPEN;
            end
        endcase
        return s;
    endfunction : switches_for

    // true when a phase change keeps the conversion order
    function automatic logic legal_step(
        input dual_slope_pkg::phase_type from_ph,
        input dual_slope_pkg::phase_type to_ph
    );
        logic ok;
        ok = 1'b0;
        unique case (from_ph)
            dual_slope_pkg::ZERO_PHASE: begin
                ok = (to_ph == dual_slope_pkg::INPUT_PHASE);
            end
            dual_slope_pkg::INPUT_PHASE: begin
                ok = (to_ph == dual_slope_pkg::REFERENCE_PHASE);
            end
            dual_slope_pkg::REFERENCE_PHASE: begin
                ok = (to_ph == dual_slope_pkg::ZERO_PHASE);
            end
            // recovering from the unused combination via auto-zero
            dual_slope_pkg::UNUSED_COMBO: begin
                ok = (to_ph == dual_slope_pkg::ZERO_PHASE);
            end
        endcase
        return ok;
    endfunction : legal_step

    // ************************************************************
    // sequencer state
    // ************************************************************
    // registered state and its next value
    dual_slope_pkg::seq_state_type state_r;
    dual_slope_pkg::seq_state_type state_nxt;
    // phase requested by the synchronised pins this cycle
    dual_slope_pkg::phase_type req_phase;

    assign req_phase = decode_phase(first_s, second_s);

    // next-state logic
    always_comb begin
        state_nxt = state_r;
        state_nxt.comp = comp_s;
        if (req_phase != state_r.phase) begin
            // break before make: one cycle with every switch open
            // so input and reference paths never overlap
            state_nxt.phase = req_phase;
            state_nxt.sw = dual_slope_pkg::SW_ALL_OPEN;
            if (!legal_step(state_r.phase, req_phase)) begin
                state_nxt.seq_err = 1'b1;
            end
        end else begin
            state_nxt.sw = switches_for(state_r.phase);
        end
    end

    // state register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= dual_slope_pkg::STATE_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs straight from the state register
    assign switches = state_r.sw;
    assign phase = state_r.phase;
    assign comp_out = state_r.comp;
    assign seq_err = state_r.seq_err;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // pins stable in one combination for two cycles
    sequence zero_held;
        (!first_s && !second_s) [*2];
    endsequence
    sequence input_held;
        (first_s && second_s) [*2];
    endsequence
    sequence ref_held;
        (!first_s && second_s) [*2];
    endsequence

    chk_zero_switches: assert property (
        zero_held |=> switches.zero_loop_switch
            && switches.zero_feedback_switch
            && !switches.input_path_switch
            && !switches.reference_path_switch)
        else $error("auto-zero switch set wrong");

    chk_input_switch: assert property (
        input_held |=> switches
            == dual_slope_pkg::switch_set_type'{1'b0, 1'b0, 1'b1, 1'b0})
        else $error("input phase switch set wrong");

    chk_ref_switches: assert property (
        ref_held |=> switches
            == dual_slope_pkg::switch_set_type'{1'b1, 1'b0, 1'b0, 1'b1})
        else $error("reference phase switch set wrong");

    // input and reference never closed together
    chk_no_overlap: assert property (
        !(switches.input_path_switch && switches.reference_path_switch))
        else $error("input and reference paths both closed");

    // phase change opens all switches for a cycle
    chk_break_make: assert property (
        $changed(phase) |-> switches == dual_slope_pkg::SW_ALL_OPEN)
        else $error("switches not opened on phase change");

    // skipping input phase flags an error
    chk_order_err: assert property (
        (phase == dual_slope_pkg::ZERO_PHASE)
            && (req_phase == dual_slope_pkg::REFERENCE_PHASE)
            |=> seq_err)
        else $error("out of order phase not flagged");

    chk_err_sticky: assert property (
        seq_err |=> seq_err)
        else $error("sequence error flag dropped");

    // comparator follows pin after three cycles
    chk_comp_latency: assert property (
        ##3 (comp_out == $past(comp_raw, 3)))
        else $error("comparator output latency wrong");

endmodule : dual_slope_phase_sequencer

// *** verification/phase_controller_model.sv ***
`timescale 1ns/1ps

// ****************************************
// controller side: sequences the phase pins
// ****************************************
module phase_controller_model #(
    parameter int IN_CYC = 12
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic ovr_en,
    input wire logic [1:0] ovr_pins,
    input wire logic comp_out,
    output logic first_ctrl_pin,
    output logic second_ctrl_pin,
    output logic [7:0] n_conv,
    output logic [15:0] reading
);
    logic [1:0] st_r; // 0 zero, 1 input, 2 reference
    logic [31:0] cnt_r; // input slope length in cycles
    logic [31:0] ref_r; // reference slope length in cycles
    logic [1:0] pins; // {first, second} from the sequence

    assign pins = (st_r == 2'h1) ? 2'h3 : (st_r == 2'h2) ? 2'h1 : 2'h0;
    // override lets a scenario break the order on purpose
    assign {first_ctrl_pin, second_ctrl_pin} = ovr_en ? ovr_pins : pins;

    // fixed input slope, then reference slope
    // 32-bit counts cover a 20 s conversion at 25 MHz
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= 2'h0;
            cnt_r <= 32'h0;
            ref_r <= 32'h0;
            n_conv <= 8'h00;
            reading <= 16'h0000;
        end else begin
            case (st_r)
                // conversions start on demand, any slow rate
                2'h0: if (start) begin
                    st_r <= 2'h1;
                    cnt_r <= 32'h0;
                end
                2'h1: begin
                    cnt_r <= cnt_r + 32'h1;
                    if (cnt_r == 32'(IN_CYC - 1)) begin
                        st_r <= 2'h2;
                        ref_r <= 32'h0;
                    end
                end
                2'h2: begin
                    ref_r <= ref_r + 32'h1;
                    if (comp_out) begin
                        st_r <= 2'h0;
                        n_conv <= n_conv + 8'h01;
                        // reference over input, 8 fraction bits
                        reading <= 16'(((ref_r + 32'h1) << 8) / IN_CYC);
                    end
                end
                default: st_r <= 2'h0;
            endcase
        end
    end
endmodule : phase_controller_model

// *** verification/test_dual_slope_phase_sequencer.sv ***
`timescale 1ns/1ps

module test_dual_slope_phase_sequencer;
    logic ref_clk, sys_rst, comp_raw, start, ovr_en, f_pin, s_pin;
    logic [7:0] n_conv; // conversions completed by the controller
    logic [15:0] reading; // reference over input, 8 fraction bits
    // input slope length handed to the controller
    localparam int IN_CYC = 12;
    // reference slope seen by the controller: 3 decode, 8 wait,
    // 3 comparator latency, 1 controller sample
    localparam int REF_CYC = 15;
    localparam logic [15:0] READ_EXP = 16'((REF_CYC << 8) / IN_CYC);
    logic [1:0] ovr_pins; // forced {first, second}
    dual_slope_pkg::switch_set_type switches;
    dual_slope_pkg::phase_type phase;
    logic comp_out, seq_err;
    int errors, n_tests;

    // ****************************************
    // clock, design and controller model
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    dual_slope_phase_sequencer dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .first_ctrl_pin(f_pin), .second_ctrl_pin(s_pin),
        .comp_raw(comp_raw), .switches(switches), .phase(phase),
        .comp_out(comp_out), .seq_err(seq_err));

    phase_controller_model #(.IN_CYC(IN_CYC)) ctl (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .start(start), .ovr_en(ovr_en),
        .ovr_pins(ovr_pins), .comp_out(comp_out), .first_ctrl_pin(f_pin),
        .second_ctrl_pin(s_pin), .n_conv(n_conv), .reading(reading));

    // ****************************************
    // helpers
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1; // let the edge's updates land
    endtask : tick

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_bit

    task automatic cmp_sw(input string nm, input logic [3:0] e);
        n_tests++;
        if (switches !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, switches);
        end
    endtask : cmp_sw

    task automatic cmp_word(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_word

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // bounded wait for a phase; running out ends the run
    task automatic wait_ph(input dual_slope_pkg::phase_type t);
        for (int i = 0; i < 100; i++) begin
            if (phase === t) return;
            tick(1);
        end
        errors++;
        $display("ERROR phase expected %0d seen %0d", t, phase);
        end_sim();
    endtask : wait_ph

    task automatic do_reset;
        sys_rst <= 1'b1;
        tick(3);
        cmp_sw("reset switches", 4'h0);
        cmp_bit("reset seq_err", 1'b0, seq_err);
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        tick(5);
        cmp_sw("zero switches", 4'hC);
    endtask : do_reset

    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_conversion(input logic [7:0] n_exp);
        @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        wait_ph(dual_slope_pkg::INPUT_PHASE);
        cmp_sw("break gap", 4'h0);
        tick(1);
        cmp_sw("input switches", 4'h2);
        wait_ph(dual_slope_pkg::REFERENCE_PHASE);
        tick(1);
        cmp_sw("reference switches", 4'h9);
        tick(6);
        cmp_sw("reference held", 4'h9);
        @(posedge ref_clk);
        comp_raw <= 1'b1;
        tick(2);
        cmp_bit("comp early", 1'b0, comp_out);
        tick(1);
        cmp_bit("comp late", 1'b1, comp_out);
        wait_ph(dual_slope_pkg::ZERO_PHASE);
        tick(1);
        cmp_sw("back to zero", 4'hC);
        cmp_bit("order ok", 1'b0, seq_err);
        cmp_word("reading", READ_EXP, reading);
        cmp_word("conversions", {8'h00, n_exp}, {8'h00, n_conv});
        @(posedge ref_clk);
        comp_raw <= 1'b0;
        tick(4);
    endtask : s_conversion

    // comparator chatter while nulling passes through, phase holds
    task automatic s_chatter;
        logic [7:0] pat;
        pat = 8'hB5;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            comp_raw <= pat[i];
            #1;
            if (i >= 3) cmp_bit("comp follow", pat[i-3], comp_out);
            cmp_word("chatter results", 16'h0000, {8'h00, n_conv});
        end
        @(posedge ref_clk);
        comp_raw <= 1'b0;
        tick(4);
        cmp_sw("zero kept", 4'hC);
    endtask : s_chatter

    // forced pins: p is the bad pair, e the switches it must give
    task automatic s_forced(input logic [1:0] p, input logic [3:0] e);
        @(posedge ref_clk);
        ovr_en <= 1'b1;
        ovr_pins <= p;
        tick(5);
        cmp_sw("forced switches", e);
        cmp_bit("order error", 1'b1, seq_err);
        @(posedge ref_clk);
        ovr_pins <= 2'h0;
        tick(5);
        cmp_sw("zero again", 4'hC);
        cmp_bit("error sticky", 1'b1, seq_err);
        @(posedge ref_clk);
        ovr_en <= 1'b0;
        do_reset();
    endtask : s_forced

    initial begin
        sys_rst = 1'b1;
        comp_raw = 1'b0;
        start = 1'b0;
        ovr_en = 1'b0;
        ovr_pins = 2'h0;
        errors = 0;
        n_tests = 0;
        do_reset();
        s_chatter();
        s_conversion(8'h01);
        s_conversion(8'h02);
        s_forced(2'h2, 4'h0);
        s_forced(2'h1, 4'h9);
        s_conversion(8'h01);
        end_sim();
    end
endmodule : test_dual_slope_phase_sequencer
